/* inc/ucr_pkg.sv */
// Constants and carrier types for the upconverter control register bank
package ucr_pkg;

  // ==========================================================
  // Serial port framing
  localparam int          UCR_INSTR_BITS = 8;
  localparam int          UCR_RW_BIT     = 7;
  localparam int          UCR_ADDR_W     = 5;
  localparam int          UCR_MAX_BITS   = 48;
  localparam logic [5:0]  UCR_BITS_WORD  = 6'h20;
  localparam logic [5:0]  UCR_BITS_SEG   = 6'h30;

  // ==========================================================
  // Register addresses
  localparam logic [4:0]  UCR_ADDR_CW3   = 5'h02;
  localparam logic [4:0]  UCR_ADDR_DAC   = 5'h03;
  localparam logic [4:0]  UCR_ADDR_RATE  = 5'h04;
  localparam logic [4:0]  UCR_ADDR_SEG0  = 5'h05;
  localparam logic [4:0]  UCR_ADDR_SEG1  = 5'h06;
  localparam logic [4:0]  UCR_ADDR_ASF   = 5'h09;

  // ==========================================================
  // Implemented-bit masks and reset values
  localparam logic [31:0] UCR_CW3_MASK   = 32'h3738_C1FE;
  localparam logic [31:0] UCR_CW3_RESET  = 32'h1738_4000;
  localparam logic [31:0] UCR_DAC_MASK   = 32'h0000_00FF;
  localparam logic [31:0] UCR_DAC_RESET  = 32'h0000_00FF;
  localparam logic [31:0] UCR_RATE_RESET = 32'h0FFF_FFFF;
  localparam logic [47:0] UCR_SEG_MASK   = 48'hFFFF_FFC0_FFC7;
  localparam logic [47:0] UCR_SEG_RESET  = 48'h0000_0000_0000;
  localparam logic [31:0] UCR_ASF_RESET  = 32'h0000_0000;

  // ==========================================================
  // Field positions
  localparam int UCR_CW3_DRV_LSB  = 28;
  localparam int UCR_CW3_BAND_LSB = 24;
  localparam int UCR_CW3_CP_LSB   = 19;
  localparam int UCR_CW3_BYP_BIT  = 15;
  localparam int UCR_CW3_RUN_BIT  = 14;
  localparam int UCR_CW3_PLL_BIT  = 8;
  localparam int UCR_CW3_N_LSB    = 1;
  localparam int UCR_DAC_LSB      = 0;
  localparam int UCR_SEG_STEP_LSB = 32;
  localparam int UCR_SEG_END_LSB  = 22;
  localparam int UCR_SEG_START_LSB = 6;
  localparam int UCR_SEG_MODE_LSB = 0;
  localparam int UCR_ASF_RATE_LSB = 16;
  localparam int UCR_ASF_SCALE_LSB = 2;
  localparam int UCR_ASF_STEP_LSB = 0;

  typedef enum logic [1:0] {
    UCR_IDLE  = 2'b00,
    UCR_INSTR = 2'b01,
    UCR_FETCH = 2'b11,
    UCR_DATA  = 2'b10
  } ucr_phase_type;

  typedef struct packed {
    logic        strobe;
    logic [4:0]  addr;
    logic [47:0] data;
  } ucr_wr_type;

  typedef struct packed {
    logic [1:0] ref_output_drive;
    logic [2:0] oscillator_band_select;
    logic [2:0] charge_pump_current;
    logic       div_bypass;
    logic       div_run;
    logic       pll_enable;
    logic [6:0] feedback_div;
  } ucr_clk_path_type;

  typedef struct packed {
    logic [15:0] step_rate;
    logic [9:0]  end_addr;
    logic [9:0]  start_addr;
    logic [2:0]  mode;
  } ucr_segment_type;

  typedef struct packed {
    logic        scale_valid;
    logic [13:0] scale;
    logic        ramp_enable;
    logic [15:0] ramp_rate;
    logic [13:0] ramp_limit;
    logic [1:0]  step_size;
  } ucr_amp_type;

  // Bits carried in the data phase; unmapped addresses frame as a word
  function automatic logic [5:0] ucr_reg_bits(input logic [4:0] addr);
    if (addr == UCR_ADDR_SEG0 || addr == UCR_ADDR_SEG1) begin
      return UCR_BITS_SEG;
    end
    return UCR_BITS_WORD;
  endfunction

endpackage

/* src/ucr_serial_port.sv */
// Serial control port shifter: instruction byte, then register data MSB first
`timescale 1ns/1ps
module ucr_serial_port
  import ucr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  input  wire logic [47:0] rd_data,
  output logic [4:0]       rd_addr,
  output ucr_wr_type       wr,
  output logic             sdo,
  output logic             sdo_oe
);

  typedef struct packed {
    logic          sclk_prev;
    ucr_phase_type phase;
    logic [5:0]    cnt;
    logic [5:0]    len;
    logic          is_read;
    logic [4:0]    addr;
    logic [47:0]   shift;
    ucr_wr_type    wr;
    logic          sdo;
    logic          sdo_oe;
  } ucr_sp_state_type;

  ucr_sp_state_type state_reg;
  ucr_sp_state_type state_next;

  always_comb begin
    logic       rise;
    logic       fall;
    logic [7:0] instr;
    rise  = sclk & ~state_reg.sclk_prev;
    fall  = ~sclk & state_reg.sclk_prev;
    instr = {state_reg.shift[6:0], sdi};
    state_next           = state_reg;
    state_next.sclk_prev = sclk;
    state_next.wr.strobe = 1'b0;
    if (cs_n) begin
      state_next.phase  = UCR_IDLE;
      state_next.cnt    = '0;
      state_next.sdo_oe = 1'b0;
    end else begin
      unique case (state_reg.phase)
        UCR_IDLE: begin
          state_next.phase = UCR_INSTR;
        end
        UCR_INSTR: begin
          if (rise) begin
            state_next.shift = {state_reg.shift[46:0], sdi};
            state_next.cnt   = state_reg.cnt + 6'h01;
            if (state_reg.cnt == 6'(UCR_INSTR_BITS - 1)) begin
              state_next.is_read = instr[UCR_RW_BIT];
              state_next.addr    = instr[UCR_ADDR_W-1:0];
              state_next.len     = ucr_reg_bits(instr[UCR_ADDR_W-1:0]);
              state_next.cnt     = '0;
              state_next.phase   = UCR_FETCH;
            end
          end
        end
        UCR_FETCH: begin
          // Read data is left aligned so the MSB leaves first
          state_next.phase = UCR_DATA;
          if (state_reg.is_read) begin
            state_next.shift  = rd_data << (UCR_MAX_BITS - int'(state_reg.len));
            state_next.sdo_oe = 1'b1;
          end
        end
        UCR_DATA: begin
          if (fall && state_reg.is_read) begin
            state_next.sdo = state_reg.shift[47];
          end
          // Extra clocks past the register length are ignored
          if (rise && state_reg.cnt < state_reg.len) begin
            state_next.shift = {state_reg.shift[46:0], sdi};
            state_next.cnt   = state_reg.cnt + 6'h01;
            if (state_reg.cnt == state_reg.len - 6'h01 && !state_reg.is_read) begin
              state_next.wr.strobe = 1'b1;
              state_next.wr.addr   = state_reg.addr;
              state_next.wr.data   = {state_reg.shift[46:0], sdi};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_addr = state_reg.addr;
  assign wr      = state_reg.wr;
  assign sdo     = state_reg.sdo;
  assign sdo_oe  = state_reg.sdo_oe;

endmodule

/* src/ucr_register_bank.sv */
// Control register bank of the quadrature upconverter, reached by serial port
//
// Overview of operation
// - Third control word sits at address 0x02, four bytes long.
// - Bits 29:28 pick reference clock output drive, reset 01b.
// - Bits 26:24 pick PLL oscillator band, reset 111b.
// - Bits 21:19 pick PLL charge pump current, reset 111b.
// - Bit 15 high bypasses the reference input divider; default uses it.
// - Bit 14 low holds the input divider in reset; default runs.
// - Bit 8 high enables the reference PLL; default bypasses it.
// - Bits 7:1 hold the 7-bit PLL feedback modulus, reset zero.
// - Address 0x03 bits 7:0 set DAC full-scale current, reset 0xFF.
// - Update-rate register at 0x04 takes effect immediately on write.
// - Update rate governs only when control word two bit 23 is set.
// - Segment zero at 0x05 acts at once, chosen on select rise.
// - Segment one at 0x06 is chosen on select pin fall.
// - Segment fields: step 47:32, end 31:22, start 15:6, mode 2:0.
// - Amplitude register at 0x09 matters only with control bit 9.
// - Bits 31:16 give ramp rate, used only with control bit 8.
// - Bits 8 and 23 both low: scale field drives amplitude directly.
// - Bit 8 low, 23 high: scale applies only while keying pin high.
// - Bit 8 high: scale field is the ramp ceiling.
// - Bits 1:0 give ramp step size, used only with control bit 8.
`timescale 1ns/1ps
module ucr_register_bank
  import ucr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  input  wire logic        io_update,
  input  wire logic        cw1_ram_enable,
  input  wire logic        cw1_osk_enable,
  input  wire logic        cw1_auto_osk,
  input  wire logic        cw1_manual_osk,
  input  wire logic        cw2_auto_update_enable,
  input  wire logic        segment_select_pin,
  input  wire logic        shift_keying_pin,
  output ucr_clk_path_type clk_path,
  output logic [7:0]       dac_full_scale_code,
  output logic [31:0]      auto_update_rate,
  output logic             auto_update_active,
  output ucr_segment_type  segment,
  output logic             segment_valid,
  output logic             segment_index,
  output ucr_amp_type      amp
);

  // ==========================================================
  // Serial port
  logic [4:0]  rd_addr;
  logic [47:0] rd_data;
  ucr_wr_type  wr;
  logic        port_sdo;
  logic        port_sdo_oe;

  ucr_serial_port u_port (
    .clk_sys (clk_sys),
    .reset   (reset),
    .sclk    (sclk),
    .cs_n    (cs_n),
    .sdi     (sdi),
    .rd_data (rd_data),
    .rd_addr (rd_addr),
    .wr      (wr),
    .sdo     (port_sdo),
    .sdo_oe  (port_sdo_oe)
  );

  // ==========================================================
  // State
  typedef struct packed {
    logic [31:0]      cw3_buf;
    logic [31:0]      cw3;
    logic [31:0]      dac_buf;
    logic [31:0]      dac;
    logic [31:0]      rate;
    logic [47:0]      seg0;
    logic [47:0]      seg1_buf;
    logic [47:0]      seg1;
    logic [31:0]      asf_buf;
    logic [31:0]      amplitude_scale_control;
    logic             upd_prev;
    logic             sel_prev;
    logic             seg_valid;
    logic             seg_index;
    ucr_clk_path_type clk_path;
    logic [7:0]       dac_code;
    logic [31:0]      rate_out;
    logic             rate_active;
    ucr_segment_type  segment;
    ucr_amp_type      amp;
  } ucr_state_type;

  ucr_state_type state_reg;
  ucr_state_type state_next;

  // ==========================================================
  // Read-back mux
  // Buffered registers read back the last written value, not the active copy
  always_comb begin
    unique case (rd_addr)
      UCR_ADDR_CW3:  rd_data = {16'h0000, state_reg.cw3_buf};
      UCR_ADDR_DAC:  rd_data = {16'h0000, state_reg.dac_buf};
      UCR_ADDR_RATE: rd_data = {16'h0000, state_reg.rate};
      UCR_ADDR_SEG0: rd_data = state_reg.seg0;
      UCR_ADDR_SEG1: rd_data = state_reg.seg1_buf;
      UCR_ADDR_ASF:  rd_data = {16'h0000, state_reg.asf_buf};
      default:       rd_data = '0;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    logic            upd;
    logic            sel_rise;
    logic            sel_fall;
    logic [47:0]     seg_src;
    logic [13:0]     scale_field;
    seg_src             = '0;
    scale_field         = '0;
    state_next          = state_reg;
    upd                 = io_update & ~state_reg.upd_prev;
    sel_rise            = segment_select_pin & ~state_reg.sel_prev;
    sel_fall            = ~segment_select_pin & state_reg.sel_prev;
    state_next.upd_prev = io_update;
    state_next.sel_prev = segment_select_pin;

    // Transfer buffers first so a write in the same cycle waits for the next
    if (upd) begin
      state_next.cw3  = state_reg.cw3_buf;
      state_next.dac  = state_reg.dac_buf;
      state_next.seg1 = state_reg.seg1_buf;
      state_next.amplitude_scale_control  = state_reg.asf_buf;
    end

    // Register writes; CW3, DAC and segment writes are masked so unassigned bits stay zero
    if (wr.strobe) begin
      unique case (wr.addr)
        UCR_ADDR_CW3: begin
          state_next.cw3_buf = wr.data[31:0] & UCR_CW3_MASK;
        end
        UCR_ADDR_DAC: begin
          state_next.dac_buf = wr.data[31:0] & UCR_DAC_MASK;
        end
        UCR_ADDR_RATE: begin
          state_next.rate = wr.data[31:0];
        end
        UCR_ADDR_SEG0: begin
          state_next.seg0 = wr.data & UCR_SEG_MASK;
        end
        UCR_ADDR_SEG1: begin
          state_next.seg1_buf = wr.data & UCR_SEG_MASK;
        end
        UCR_ADDR_ASF: begin
          state_next.asf_buf = wr.data[31:0];
        end
        default: begin
          state_next.rate = state_reg.rate;
        end
      endcase
    end

    // ==========================================================
    // Clock path decode
    state_next.clk_path.ref_output_drive =
      state_reg.cw3[UCR_CW3_DRV_LSB +: 2];
    state_next.clk_path.oscillator_band_select =
      state_reg.cw3[UCR_CW3_BAND_LSB +: 3];
    state_next.clk_path.charge_pump_current =
      state_reg.cw3[UCR_CW3_CP_LSB +: 3];
    state_next.clk_path.div_bypass =
      state_reg.cw3[UCR_CW3_BYP_BIT];
    state_next.clk_path.div_run =
      state_reg.cw3[UCR_CW3_RUN_BIT];
    state_next.clk_path.pll_enable =
      state_reg.cw3[UCR_CW3_PLL_BIT];
    state_next.clk_path.feedback_div =
      state_reg.cw3[UCR_CW3_N_LSB +: 7];

    // ==========================================================
    // DAC current and automatic update rate
    state_next.dac_code    = state_reg.dac[UCR_DAC_LSB +: 8];
    state_next.rate_out    = state_reg.rate;
    state_next.rate_active = cw2_auto_update_enable;

    // ==========================================================
    // Segment selection by select pin edges
    // Edges while RAM playback is off are ignored and leave the choice
    if (cw1_ram_enable && sel_rise) begin
      state_next.seg_valid = 1'b1;
      state_next.seg_index = 1'b0;
    end else if (cw1_ram_enable && sel_fall) begin
      state_next.seg_valid = 1'b1;
      state_next.seg_index = 1'b1;
    end else if (!cw1_ram_enable) begin
      state_next.seg_valid = 1'b0;
    end
    // Segment zero edits reach the output at once, no transfer needed
    seg_src = state_next.seg_index ? state_reg.seg1 : state_reg.seg0;
    state_next.segment.step_rate =
      seg_src[UCR_SEG_STEP_LSB +: 16];
    state_next.segment.end_addr =
      seg_src[UCR_SEG_END_LSB +: 10];
    state_next.segment.start_addr =
      seg_src[UCR_SEG_START_LSB +: 10];
    state_next.segment.mode =
      seg_src[UCR_SEG_MODE_LSB +: 3];

    // ==========================================================
    // Amplitude scale and ramp settings
    scale_field    = state_reg.amplitude_scale_control[UCR_ASF_SCALE_LSB +: 14];
    state_next.amp = '0;
    if (cw1_osk_enable) begin
      if (cw1_auto_osk) begin
        state_next.amp.ramp_enable = 1'b1;
        state_next.amp.ramp_rate   =
          state_reg.amplitude_scale_control[UCR_ASF_RATE_LSB +: 16];
        state_next.amp.ramp_limit  = scale_field;
        state_next.amp.step_size   =
          state_reg.amplitude_scale_control[UCR_ASF_STEP_LSB +: 2];
      end else if (cw1_manual_osk) begin
        state_next.amp.scale_valid = shift_keying_pin;
        state_next.amp.scale       = shift_keying_pin ? scale_field : '0;
      end else begin
        state_next.amp.scale_valid = 1'b1;
        state_next.amp.scale       = scale_field;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg          <= '0;
      state_reg.cw3_buf  <= UCR_CW3_RESET;
      state_reg.cw3      <= UCR_CW3_RESET;
      state_reg.dac_buf  <= UCR_DAC_RESET;
      state_reg.dac      <= UCR_DAC_RESET;
      state_reg.rate     <= UCR_RATE_RESET;
      state_reg.seg0     <= UCR_SEG_RESET;
      state_reg.seg1_buf <= UCR_SEG_RESET;
      state_reg.seg1     <= UCR_SEG_RESET;
      state_reg.asf_buf  <= UCR_ASF_RESET;
      state_reg.amplitude_scale_control      <= UCR_ASF_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  assign sdo                 = port_sdo;
  assign sdo_oe              = port_sdo_oe;
  assign clk_path            = state_reg.clk_path;
  assign dac_full_scale_code = state_reg.dac_code;
  assign auto_update_rate    = state_reg.rate_out;
  assign auto_update_active  = state_reg.rate_active;
  assign segment             = state_reg.segment;
  assign segment_valid       = state_reg.seg_valid;
  assign segment_index       = state_reg.seg_index;
  assign amp                 = state_reg.amp;

endmodule

/* test/ucr_host_model.sv */
// Host side of the serial control port: frames one register access at a time
`timescale 1ns/1ps
module ucr_host_model
  import ucr_pkg::*;
(
  input  wire logic clk_sys,
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b1;
  end

  // ==========================================================
  // Frame: instruction byte then n data bits, MSB first
  // Four clk_sys cycles per half period keep clear of the three-cycle minimum
  task automatic xfer(input logic rd, input logic [4:0] a, input logic [47:0] wd,
                      input int n, output logic [47:0] q);
    logic [55:0] sh;
    sh = {rd, 2'b00, a, wd << (48 - n)};
    q = 48'h0;
    @(posedge clk_sys) cs_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 8 + n; i++) begin
      @(posedge clk_sys) begin
        sclk <= 1'b0;
        sdi  <= sh[55 - i];
      end
      repeat (3) @(posedge clk_sys);
      @(posedge clk_sys) begin
        sclk <= 1'b1;
        if (i >= 8) begin
          q = {q[46:0], sdo};
        end
      end
      repeat (3) @(posedge clk_sys);
    end
    @(posedge clk_sys) sclk <= 1'b0;
    repeat (3) @(posedge clk_sys);
    // Released data line shows the inverse of the last bit, never a stale copy
    @(posedge clk_sys) begin
      cs_n <= 1'b1;
      sdi  <= ~sdi;
    end
  endtask
endmodule

/* test/ucr_bank_monitor.sv */
// Concurrent checks on the ports of the upconverter control register bank
`timescale 1ns/1ps
module ucr_bank_monitor
  import ucr_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        cs_n,
  input wire logic        sdo_oe,
  input wire logic        cw1_ram_enable,
  input wire logic        cw1_osk_enable,
  input wire logic        cw1_auto_osk,
  input wire logic        cw1_manual_osk,
  input wire logic        cw2_auto_update_enable,
  input wire logic        segment_select_pin,
  input wire logic        shift_keying_pin,
  input ucr_clk_path_type clk_path,
  input wire logic [7:0]  dac_full_scale_code,
  input wire logic [31:0] auto_update_rate,
  input wire logic        auto_update_active,
  input wire logic        segment_valid,
  input wire logic        segment_index,
  input ucr_amp_type      amp
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // ==========================================================
  // Assertions
  clk_reset_a: assert property ($fell(reset) |=>
    clk_path == {2'h1, 3'h7, 3'h7, 3'h2, 7'h00}) else $error("clock path reset value");
  dac_reset_a: assert property ($fell(reset) |=>
    dac_full_scale_code == 8'hFF && auto_update_rate == 32'h0FFF_FFFF)
    else $error("dac code or update rate reset value");
  rate_idle_a: assert property ((!cw2_auto_update_enable)[*3] |->
    !auto_update_active) else $error("auto update active while disabled");
  seg_rise_a: assert property (cw1_ram_enable && $rose(segment_select_pin) |->
    ##[1:3] segment_valid && !segment_index) else $error("segment zero not chosen");
  seg_fall_a: assert property (cw1_ram_enable && $fell(segment_select_pin) |->
    ##[1:3] segment_valid && segment_index) else $error("segment one not chosen");
  seg_off_a: assert property ((!cw1_ram_enable)[*3] |->
    !segment_valid) else $error("segment valid without ram");
  amp_off_a: assert property ((!cw1_osk_enable)[*3] |-> amp == 48'h0)
    else $error("amplitude control active while off");
  key_low_a: assert property ((cw1_osk_enable && !cw1_auto_osk && cw1_manual_osk
    && !shift_keying_pin)[*3] |-> !amp.scale_valid) else $error("scale with keying pin low");
  ramp_on_a: assert property ((cw1_osk_enable && cw1_auto_osk)[*3] |->
    amp.ramp_enable) else $error("ramp not enabled");
  port_idle_a: assert property (cs_n[*3] |-> !sdo_oe) else $error("sdo driven between frames");

  cover property ($rose(sdo_oe));
  cover property (segment_valid && segment_index);
  cover property (amp.ramp_enable);
endmodule

bind ucr_register_bank ucr_bank_monitor ucr_bank_monitor_i (.*);

/* test/tb.sv */
// Self-checking bench for the upconverter control register bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb
  import ucr_pkg::*;
;
  logic clk_sys, reset, sclk, cs_n, sdi, sdo, sdo_oe, io_update;
  logic cw1_ram_enable, cw1_osk_enable, cw1_auto_osk, cw1_manual_osk;
  logic cw2_auto_update_enable, segment_select_pin, shift_keying_pin;
  logic auto_update_active, segment_valid, segment_index;
  logic [7:0]       dac_full_scale_code;
  logic [31:0]      auto_update_rate;
  logic [47:0]      q;
  ucr_clk_path_type clk_path;
  ucr_segment_type  segment;
  ucr_amp_type      amp;
  int               mismatches = 0;
  int               tests_run = 0;

  ucr_register_bank ucr_register_bank_i (.*);
  ucr_host_model ucr_host_model_i (.*);

  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;

  // ==========================================================
  // Helpers
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  function automatic int nbits(input logic [4:0] a);
    return (a == UCR_ADDR_SEG0 || a == UCR_ADDR_SEG1) ? 48 : 32;
  endfunction
  function automatic logic [38:0] fields(input logic [47:0] v);
    return {v[47:32], v[31:22], v[15:6], v[2:0]};
  endfunction
  task automatic wr(input logic [4:0] a, input logic [47:0] d);
    ucr_host_model_i.xfer(1'b0, a, d, nbits(a), q);
  endtask
  task automatic rd(input logic [4:0] a);
    ucr_host_model_i.xfer(1'b1, a, 48'h0, nbits(a), q);
  endtask
  task automatic upd;
    @(posedge clk_sys) io_update <= 1'b1;
    tick(2);
    @(posedge clk_sys) io_update <= 1'b0;
    tick(4);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [4:0]  ad [7] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h09, 5'h07};
    logic [47:0] ex [7] = '{48'h1738_4000, 48'hFF, 48'h0FFF_FFFF, 48'h0, 48'h0, 48'h0, 48'h0};
    `CHK("clk_path", {2'h1, 3'h7, 3'h7, 3'h2, 7'h00}, clk_path)
    // Unmapped write must leave every register at its reset value
    wr(5'h07, 48'hFFFF_FFFF);
    for (int i = 0; i < 7; i++) begin
      rd(ad[i]);
      `CHK("reset read", ex[i], q)
    end
    $display("test reset done");
  endtask

  task automatic t_cw3;
    wr(UCR_ADDR_CW3, 48'hAD51_8357);
    `CHK("clk_path held", {2'h1, 3'h7, 3'h7, 3'h2, 7'h00}, clk_path)
    rd(UCR_ADDR_CW3);
    `CHK("cw3 read", 48'h2510_8156, q)
    wr(UCR_ADDR_DAC, 48'hA5C3);
    rd(UCR_ADDR_DAC);
    `CHK("dac read", 48'hC3, q)
    upd();
    `CHK("clk_path", {2'h2, 3'h5, 3'h2, 3'h5, 7'h2B}, clk_path)
    `CHK("dac code", 8'hC3, dac_full_scale_code)
    $display("test clock path done");
  endtask

  task automatic t_rate;
    wr(UCR_ADDR_RATE, 48'h1234_5678);
    `CHK("rate", 32'h1234_5678, auto_update_rate)
    @(posedge clk_sys) cw2_auto_update_enable <= 1'b1;
    tick(4);
    `CHK("active on", 1'b1, auto_update_active)
    @(posedge clk_sys) cw2_auto_update_enable <= 1'b0;
    tick(4);
    `CHK("active off", 1'b0, auto_update_active)
    $display("test update rate done");
  endtask

  task automatic t_seg;
    // Segment zero written after the update: it must act without one
    wr(UCR_ADDR_SEG1, 48'hFEDC_BA98_7654);
    upd();
    wr(UCR_ADDR_SEG0, 48'h1234_8765_4321);
    rd(UCR_ADDR_SEG0);
    `CHK("seg0 read", 48'h1234_8740_4301, q)
    @(posedge clk_sys) cw1_ram_enable <= 1'b1;
    tick(4);
    @(posedge clk_sys) segment_select_pin <= 1'b1;
    tick(5);
    `CHK("seg0", fields(48'h1234_8765_4321), segment)
    `CHK("seg0 flags", 2'b10, {segment_valid, segment_index})
    @(posedge clk_sys) segment_select_pin <= 1'b0;
    tick(5);
    `CHK("seg1", fields(48'hFEDC_BA98_7654), segment)
    `CHK("seg1 flags", 2'b11, {segment_valid, segment_index})
    @(posedge clk_sys) cw1_ram_enable <= 1'b0;
    tick(5);
    `CHK("seg off", 1'b0, segment_valid)
    $display("test segments done");
  endtask

  task automatic t_amp;
    wr(UCR_ADDR_ASF, 48'hABCD_5679);
    upd();
    `CHK("amp off", 48'h0, amp)
    @(posedge clk_sys) cw1_osk_enable <= 1'b1;
    tick(4);
    `CHK("direct", {1'b1, 14'h159E}, {amp.scale_valid, amp.scale})
    @(posedge clk_sys) cw1_manual_osk <= 1'b1;
    tick(4);
    `CHK("key low", 1'b0, amp.scale_valid)
    @(posedge clk_sys) shift_keying_pin <= 1'b1;
    tick(4);
    `CHK("key high", {1'b1, 14'h159E}, {amp.scale_valid, amp.scale})
    @(posedge clk_sys) cw1_auto_osk <= 1'b1;
    tick(4);
    `CHK("ramp", {1'b1, 16'hABCD, 14'h159E, 2'h1},
      {amp.ramp_enable, amp.ramp_rate, amp.ramp_limit, amp.step_size})
    $display("test amplitude done");
  endtask

  // ==========================================================
  // Verdict and main sequence
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    io_update = 1'b0;
    cw1_ram_enable = 1'b0;
    cw1_osk_enable = 1'b0;
    cw1_auto_osk = 1'b0;
    cw1_manual_osk = 1'b0;
    cw2_auto_update_enable = 1'b0;
    segment_select_pin = 1'b0;
    shift_keying_pin = 1'b0;
    tick(12);
    @(posedge clk_sys) reset <= 1'b0;
    tick(2);
    t_reset();
    t_cw3();
    t_rate();
    t_seg();
    t_amp();
    end_of_test();
  end

  // About six times the expected run length
  initial begin
    #2000000;
    mismatches++;
    end_of_test();
  end
endmodule
